/* inc/acac_pkg.sv */
// Purpose: shared constants and types for the converter sequencing and alert block
// Assumes: 125 MHz core clock, a 512 kHz conversion oscillator derived from it
// Notes:   register pointers, config field positions, reset values and timings live here
package acac_pkg;

  // register pointer values carried by link commands
  localparam logic [1:0] PTR_RESULT = 2'h0;
  localparam logic [1:0] PTR_CONFIG = 2'h1;
  localparam logic [1:0] PTR_LOWER  = 2'h2;
  localparam logic [1:0] PTR_UPPER  = 2'h3;

  // conversion_configuration field positions
  localparam int CFG_START_BIT  = 15;
  localparam int CFG_MODE_BIT   = 8;
  localparam int CFG_RATE_LSB   = 5;
  localparam int CFG_WINDOW_BIT = 4;
  localparam int CFG_POL_BIT    = 3;
  localparam int CFG_LATCH_BIT  = 2;
  localparam int CFG_QUE_LSB    = 0;

  // reset values
  localparam logic [15:0] CFG_RESET   = 16'h8583;
  localparam logic [15:0] LOWER_RESET = 16'h8000;
  localparam logic [15:0] UPPER_RESET = 16'h7fff;

  // queue code that switches the comparator off
  localparam logic [1:0] QUE_OFF = 2'h3;

  // slave address base; the two strap bits select one of four
  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h48;

  // clocking and timing
  localparam int REF_CLK_HZ     = 125000000;
  localparam int CLK_PERIOD_NS  = 8;
  localparam int OSC_HZ         = 512000;
  localparam int OSC_DIV_CYCLES = REF_CLK_HZ / OSC_HZ;
  localparam int POWERUP_NS     = 25000;
  localparam int POWERUP_CYCLES = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READY_PULSE_NS = 8000;
  localparam int READY_CYCLES   = READY_PULSE_NS / CLK_PERIOD_NS;

  // oscillator ticks per conversion, index = rate_select (rates in centi-samples/s)
  localparam int CONV_TICKS [8] = '{
    OSC_HZ * 100 / 625,    OSC_HZ * 100 / 1250,  OSC_HZ * 100 / 2500,
    OSC_HZ * 100 / 5000,   OSC_HZ * 100 / 10000, OSC_HZ * 100 / 25000,
    OSC_HZ * 100 / 50000,  OSC_HZ * 100 / 100000
  };

  // link command kinds
  typedef enum logic [1:0] {
    OP_WRITE,
    OP_READ,
    OP_GCALL_RESET,
    OP_ALERT_RESP
  } acac_op_t;

  // converter power and conversion sequencing
  typedef enum logic [1:0] {
    ST_POWER_DOWN,
    ST_POWER_UP,
    ST_CONVERTING
  } acac_conv_state_t;

  // one command from the link transaction layer
  typedef struct packed {
    acac_op_t    op;
    logic [1:0]  ptr;
    logic [15:0] data;
    logic        won;
  } acac_cmd_t;

  // answer to a command
  typedef struct packed {
    logic [15:0] data;
    logic        nack;
  } acac_resp_t;

  // link-domain state
  typedef struct packed {
    logic       busy;
    logic       req_tog;
    acac_cmd_t  cmd;
    logic [2:0] ack_sync;
    logic       ack_seen;
    logic       resp_valid;
    acac_resp_t resp;
  } acac_link_t;

  // core-domain state
  typedef struct packed {
    logic [2:0]       req_sync;
    logic             req_seen;
    logic             ack_tog;
    acac_resp_t       resp;
    logic [2:0][1:0]  addr_sync;
    logic [1:0]       addr;
    logic [15:0]      cfg;
    logic [15:0]      lower;
    logic [15:0]      upper;
    logic [15:0]      result;
    acac_conv_state_t st;
    logic [11:0]      pu_cnt;
    logic [7:0]       osc_cnt;
    logic [16:0]      tick_cnt;
    logic [2:0]       act_rate;
    logic             alert;
    logic             hi_flag;
    logic [2:0]       que_cnt;
    logic             rdy_level;
    logic [9:0]       rdy_cnt;
    logic             alert_oe;
    logic             alert_out;
  } acac_core_t;

  localparam acac_link_t LINK_RESET = '{default: '0};

  localparam acac_core_t CORE_RESET = '{
    st:      ST_POWER_DOWN,
    cfg:     CFG_RESET,
    lower:   LOWER_RESET,
    upper:   UPPER_RESET,
    default: '0
  };

endpackage

/* rtl/acac_top.sv */
// Purpose: conversion sequencing and alert/ready pin logic of a small delta-sigma converter
// Assumes: a link transaction layer on link_clk hands over decoded register commands;
//          sample_data is the filter output on ref_clk, valid at the end of a conversion
// Notes:   link commands cross by toggle handshake; one command in flight at a time
`timescale 1ns/1ps
module acac_top #(
  parameter int OSC_DIV    = acac_pkg::OSC_DIV_CYCLES,
  parameter int RATE_SHIFT = 0
) (
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  input  wire logic                 link_clk,
  input  wire logic                 lk_req_valid,
  input  wire acac_pkg::acac_cmd_t  lk_req,
  output logic                      lk_busy,
  output logic                      lk_resp_valid,
  output logic [15:0]               lk_resp_data,
  output logic                      lk_resp_nack,
  input  wire logic [1:0]           addr_strap,
  input  wire logic [15:0]          sample_data,
  output logic                      alert_out,
  output logic                      alert_oe
);

  acac_pkg::acac_link_t l;
  acac_pkg::acac_link_t next_l;
  acac_pkg::acac_core_t s;
  acac_pkg::acac_core_t next_s;

  // oscillator ticks for one conversion at a rate code, shortened for simulation
  function automatic logic [16:0] conv_ticks(input logic [2:0] rate);
    logic [16:0] t;
    t = 17'(acac_pkg::CONV_TICKS[rate] >> RATE_SHIFT);
    return (t == 17'h0) ? 17'h1 : t;
  endfunction

  // consecutive exceeding results needed for a queue code
  function automatic logic [2:0] que_need(input logic [1:0] que);
    logic [2:0] n;
    unique case (que)
      2'h0:    n = 3'h1;
      2'h1:    n = 3'h2;
      default: n = 3'h4;
    endcase
    return n;
  endfunction

  // register read mux; start/status reads 1 only while powered down
  function automatic logic [15:0] read_word(input acac_pkg::acac_core_t c,
                                            input logic [1:0]           ptr);
    logic [15:0] w;
    unique case (ptr)
      acac_pkg::PTR_RESULT: w = c.result;
      acac_pkg::PTR_CONFIG:
      begin
        w = c.cfg;
        w[acac_pkg::CFG_START_BIT] = (c.st == acac_pkg::ST_POWER_DOWN);
      end
      acac_pkg::PTR_LOWER:  w = c.lower;
      default:              w = c.upper;
    endcase
    return w;
  endfunction

  // link side: take one command, flip the request toggle, wait for the answer toggle
  always_comb
  begin
    logic ack_event;
    ack_event = 1'b0;
    next_l = l;
    next_l.resp_valid = 1'b0;
    next_l.ack_sync = {l.ack_sync[1:0], s.ack_tog};
    ack_event = (l.ack_sync[1] == l.ack_sync[2]) && (l.ack_sync[2] != l.ack_seen);
    if (lk_req_valid && !l.busy)
    begin
      next_l.cmd = lk_req;
      next_l.req_tog = ~l.req_tog;
      next_l.busy = 1'b1;
    end
    if (ack_event)
    begin
      next_l.ack_seen = l.ack_sync[2];
      next_l.busy = 1'b0;
      next_l.resp_valid = 1'b1;
      next_l.resp = s.resp;              // held stable by the core since its toggle
    end
  end

  // link-domain state register
  always_ff @(posedge link_clk or posedge reset)
  begin
    if (reset)
      l <= acac_pkg::LINK_RESET;
    else
      l <= next_l;
  end

  // core side: commands, conversion sequencing, comparator and pin drive
  always_comb
  begin
    logic       new_req;
    logic       latched;
    logic       rdy_mode;
    logic       que_off;
    logic       done;
    logic       start_single;
    logic       above;
    logic       below;
    logic       exceed;
    logic       active;
    logic [2:0] cnt;
    logic       gcall;
    gcall = 1'b0;
    new_req = 1'b0;
    latched = 1'b0;
    rdy_mode = 1'b0;
    que_off = 1'b0;
    done = 1'b0;
    start_single = 1'b0;
    above = 1'b0;
    below = 1'b0;
    exceed = 1'b0;
    active = 1'b0;
    cnt = 3'h0;
    next_s = s;

    // synchronisers for the request toggle and the address strap
    next_s.req_sync = {s.req_sync[1:0], l.req_tog};
    next_s.addr_sync = {s.addr_sync[1], s.addr_sync[0], addr_strap};
    if (s.addr_sync[1] == s.addr_sync[2])
      next_s.addr = s.addr_sync[2];
    new_req = (s.req_sync[1] == s.req_sync[2]) && (s.req_sync[2] != s.req_seen);

    latched = s.cfg[acac_pkg::CFG_LATCH_BIT];
    que_off = (s.cfg[acac_pkg::CFG_QUE_LSB +: 2] == acac_pkg::QUE_OFF);
    rdy_mode = s.upper[15] && !s.lower[15] && !que_off;

    // command handling; clears here are overridden by a set from a finishing conversion
    if (new_req)
    begin
      next_s.req_seen = s.req_sync[2];
      next_s.ack_tog = ~s.ack_tog;
      next_s.resp = '{data: 16'h0000, nack: 1'b0};
      unique case (l.cmd.op)
        acac_pkg::OP_WRITE:
        begin
          unique case (l.cmd.ptr)
            acac_pkg::PTR_CONFIG:
            begin
              next_s.cfg = l.cmd.data;   // running conversion keeps its own copy of the rate only (act_rate)
              start_single = l.cmd.data[acac_pkg::CFG_START_BIT]
                           && l.cmd.data[acac_pkg::CFG_MODE_BIT]
                           && (s.st == acac_pkg::ST_POWER_DOWN);
            end
            acac_pkg::PTR_LOWER: next_s.lower = l.cmd.data;
            acac_pkg::PTR_UPPER: next_s.upper = l.cmd.data;
            default:             next_s.resp.nack = 1'b0;                   // result is read-only
          endcase
        end
        acac_pkg::OP_READ:
        begin
          next_s.resp.data = read_word(s, l.cmd.ptr);
          if (latched && !rdy_mode
              && (l.cmd.ptr == acac_pkg::PTR_RESULT || l.cmd.ptr == acac_pkg::PTR_CONFIG))
            next_s.alert = 1'b0;
        end
        acac_pkg::OP_GCALL_RESET:
          gcall = 1'b1;
        default:
        begin
          // alert response: only a latched, asserting comparator answers
          if (latched && s.alert && !rdy_mode && !que_off)
          begin
            next_s.resp.data = {8'h00, acac_pkg::SLAVE_ADDR_BASE + {5'h00, s.addr},
                                s.hi_flag};
            if (l.cmd.won)
              next_s.alert = 1'b0;       // a lost arbitration keeps the alert
          end
          else
            next_s.resp.nack = 1'b1;
        end
      endcase
    end

    // conversion sequencing off the divided oscillator
    unique case (s.st)
      acac_pkg::ST_POWER_DOWN:
      begin
        if (start_single || !next_s.cfg[acac_pkg::CFG_MODE_BIT])
        begin
          next_s.st = acac_pkg::ST_POWER_UP;
          next_s.pu_cnt = 12'h000;
        end
      end
      acac_pkg::ST_POWER_UP:
      begin
        next_s.pu_cnt = s.pu_cnt + 12'h001;
        if (s.pu_cnt == 12'(acac_pkg::POWERUP_CYCLES - 1))
        begin
          next_s.st = acac_pkg::ST_CONVERTING;
          next_s.act_rate = next_s.cfg[acac_pkg::CFG_RATE_LSB +: 3];
          next_s.osc_cnt = 8'h00;
          next_s.tick_cnt = 17'h00000;
          next_s.rdy_level = 1'b0;
        end
      end
      default:
      begin
        next_s.osc_cnt = s.osc_cnt + 8'h01;
        if (s.osc_cnt == 8'(OSC_DIV - 1))
        begin
          next_s.osc_cnt = 8'h00;
          next_s.tick_cnt = s.tick_cnt + 17'h00001;
          done = (s.tick_cnt == conv_ticks(s.act_rate) - 17'h00001);
        end
      end
    endcase

    // end of conversion: store, then restart or power down
    if (done)
    begin
      next_s.result = sample_data;
      next_s.osc_cnt = 8'h00;
      next_s.tick_cnt = 17'h00000;
      if (!next_s.cfg[acac_pkg::CFG_MODE_BIT])
        next_s.act_rate = next_s.cfg[acac_pkg::CFG_RATE_LSB +: 3];
      else
        next_s.st = acac_pkg::ST_POWER_DOWN;
    end

    // ready pulse countdown
    if (s.rdy_cnt != 10'h000)
      next_s.rdy_cnt = s.rdy_cnt - 10'h001;

    // ready signalling or comparator evaluation at each finished conversion
    if (done && rdy_mode)
    begin
      if (s.cfg[acac_pkg::CFG_MODE_BIT])
        next_s.rdy_level = 1'b1;
      else
        next_s.rdy_cnt = 10'(acac_pkg::READY_CYCLES);
    end
    else if (done && !que_off)
    begin
      above = $signed(sample_data) > $signed(s.upper);
      below = $signed(sample_data) < $signed(s.lower);
      exceed = s.cfg[acac_pkg::CFG_WINDOW_BIT] ? (above || below) : above;
      cnt = (s.que_cnt == 3'h4) ? 3'h4 : s.que_cnt + 3'h1;
      next_s.que_cnt = exceed ? cnt : 3'h0;
      if (exceed && cnt >= que_need(s.cfg[acac_pkg::CFG_QUE_LSB +: 2]))
      begin
        next_s.alert = 1'b1;
        next_s.hi_flag = above;
      end
      else if (!latched)
      begin
        if (s.cfg[acac_pkg::CFG_WINDOW_BIT] ? !exceed : below)
          next_s.alert = 1'b0;
      end
    end
    else if (que_off)
    begin
      next_s.alert = 1'b0;
      next_s.que_cnt = 3'h0;
    end

    // pin drive from the next state: open drain, low only when pulling
    active = rdy_mode ? (next_s.rdy_level || next_s.rdy_cnt != 10'h000) : next_s.alert;
    if (next_s.cfg[acac_pkg::CFG_QUE_LSB +: 2] == acac_pkg::QUE_OFF)
      next_s.alert_oe = 1'b0;
    else if (next_s.cfg[acac_pkg::CFG_POL_BIT])
      next_s.alert_oe = !active;
    else
      next_s.alert_oe = active;
    next_s.alert_out = 1'b0;

    // general-call reset applied last, so a finishing conversion cannot leave state behind
    if (gcall)
    begin
      next_s = acac_pkg::CORE_RESET;
      next_s.req_sync = {s.req_sync[1:0], l.req_tog};
      next_s.req_seen = s.req_sync[2];
      next_s.ack_tog = ~s.ack_tog;
      next_s.addr_sync = {s.addr_sync[1], s.addr_sync[0], addr_strap};
      next_s.addr = s.addr;
    end
  end

  // core-domain state register
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      s <= acac_pkg::CORE_RESET;
    else
      s <= next_s;
  end

  // outputs straight from flops
  assign lk_busy       = l.busy;
  assign lk_resp_valid = l.resp_valid;
  assign lk_resp_data  = l.resp.data;
  assign lk_resp_nack  = l.resp.nack;
  assign alert_out     = s.alert_out;
  assign alert_oe      = s.alert_oe;

endmodule

/* verification/acac_asserts.sv */
// Purpose: port-level checks of acac_top
// Assumes: one reset serves both clock domains
// Notes:   link handshake on link_clk, pin checks on ref_clk
`timescale 1ns/1ps
module acac_asserts (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        link_clk,
  input wire logic        lk_req_valid,
  input wire logic        lk_busy,
  input wire logic        lk_resp_valid,
  input wire logic [15:0] lk_resp_data,
  input wire logic        lk_resp_nack,
  input wire logic        alert_out,
  input wire logic        alert_oe
);
  // a command is taken, then answered inside the synchroniser bound
  sequence s_take;
    lk_req_valid && !lk_busy;
  endsequence
  sequence s_answer;
    lk_busy ##[1:12] lk_resp_valid;
  endsequence

  a_take_answer:
    assert property (@(posedge link_clk) disable iff (reset) s_take |=> s_answer)
    else $error("command not answered in time");
  a_valid_pulse:
    assert property (@(posedge link_clk) disable iff (reset) lk_resp_valid |=> !lk_resp_valid)
    else $error("answer strobe longer than one cycle");
  a_busy_ends:
    assert property (@(posedge link_clk) disable iff (reset) $fell(lk_busy) |-> lk_resp_valid)
    else $error("busy dropped without an answer");
  a_answer_frees:
    assert property (@(posedge link_clk) disable iff (reset) lk_resp_valid |-> !lk_busy)
    else $error("busy still high at answer");
  a_answer_owed:
    assert property (@(posedge link_clk) disable iff (reset) lk_resp_valid |-> $past(lk_busy))
    else $error("answer without a command in flight");
  a_data_held:
    assert property (@(posedge link_clk) disable iff (reset)
      !lk_resp_valid |-> $stable({lk_resp_data, lk_resp_nack}))
    else $error("answer data changed between answers");
  a_drain_low:
    assert property (@(posedge ref_clk) disable iff (reset) alert_out == 1'b0)
    else $error("alert pin driven high");
  a_wake_quiet:
    assert property (@(posedge ref_clk) disable iff (reset)
      $fell(reset) |-> !alert_oe ##1 !alert_oe)
    else $error("alert pin pulled after reset");
endmodule

bind acac_top acac_asserts u_chk (.ref_clk, .reset, .link_clk, .lk_req_valid, .lk_busy,
  .lk_resp_valid, .lk_resp_data, .lk_resp_nack, .alert_out, .alert_oe);

/* verification/acac_host.sv */
// Purpose: link-side host model issuing commands to acac_top
// Assumes: one command in flight at a time
// Notes:   released command lines carry the inverted pattern
`timescale 1ns/1ps
module acac_host (
  input  wire logic           link_clk,
  input  wire logic           lk_busy,
  input  wire logic           lk_resp_valid,
  input  wire logic [15:0]    lk_resp_data,
  input  wire logic           lk_resp_nack,
  output acac_pkg::acac_cmd_t lk_req,
  output logic                lk_req_valid
);
  logic [15:0] rd_data;
  logic        rd_nack;
  logic        lost;
  // idle command lines
  initial
  begin
    lk_req = '0;
    lk_req_valid = 1'b0;
  end
  // offer, hold until taken, release, then await the answer
  task automatic xfer(input acac_pkg::acac_op_t op, input logic [1:0] p,
                      input logic [15:0] d, input logic w);
    int   n;
    logic ok;
    n = 0;
    @(posedge link_clk);
    #1;
    lk_req = '{op: op, ptr: p, data: d, won: w};
    lk_req_valid = 1'b1;
    do
    begin
      ok = !lk_busy;
      @(posedge link_clk);
      #1;
      n++;
    end while (!ok && n < 20);
    lk_req_valid = 1'b0;
    lk_req = acac_pkg::acac_cmd_t'(~lk_req);
    while (!lk_resp_valid && n < 40)
    begin
      @(posedge link_clk);
      #1;
      n++;
    end
    rd_data = lk_resp_data;
    rd_nack = lk_resp_nack;
    lost = !lk_resp_valid;
  endtask
endmodule

/* verification/tb_acac_top.sv */
// Purpose: self-checking bench for acac_top over link commands
// Assumes: OSC_DIV and RATE_SHIFT shrink conversion times
// Notes:   alert_oe high means the pin is pulled low
`timescale 1ns/1ps
module tb_acac_top;
  localparam int         DIV = 4;
  localparam int         SH = 8;
  localparam logic [6:0] ADR = acac_pkg::SLAVE_ADDR_BASE + 7'h1;
  logic                  ref_clk, link_clk, reset, lk_req_valid, lk_busy;
  logic                  lk_resp_valid, lk_resp_nack, alert_out, alert_oe;
  logic [1:0]            addr_strap;
  logic [15:0]           sample_data, lk_resp_data, c, rv;
  acac_pkg::acac_cmd_t   lk_req;
  int                    bad_count = 0;
  int                    n_tests = 0;
  int                    cycles = 0;
  int                    k, r;

  // core clock 8 ns, link clock 6 ns
  always #4 ref_clk = ~ref_clk;
  always #3 link_clk = ~link_clk;

  acac_top #(.OSC_DIV(DIV), .RATE_SHIFT(SH)) DUT (.ref_clk, .reset, .link_clk,
    .lk_req_valid, .lk_req, .lk_busy, .lk_resp_valid, .lk_resp_data, .lk_resp_nack,
    .addr_strap, .sample_data, .alert_out, .alert_oe);
  acac_host host (.link_clk, .lk_busy, .lk_resp_valid, .lk_resp_data, .lk_resp_nack,
    .lk_req, .lk_req_valid);

  // verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // word compare
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // pin compare
  task automatic pin(input logic e);
    chk("alert_oe", {15'h0, e}, {15'h0, alert_oe});
  endtask
  // one link command
  task automatic cmd(input acac_pkg::acac_op_t op, input logic [1:0] p,
                     input logic [15:0] d, input logic w);
    host.xfer(op, p, d, w);
    rv = host.rd_data;
    chk("answer missing", 16'h0, {15'h0, host.lost});
  endtask
  task automatic wr(input logic [1:0] p, input logic [15:0] d);
    cmd(acac_pkg::OP_WRITE, p, d, 1'b0);
  endtask
  task automatic rdc(input logic [1:0] p, input logic [15:0] e);
    cmd(acac_pkg::OP_READ, p, 16'h0, 1'b0);
    chk($sformatf("ptr %0d", p), e, rv);
  endtask
  task automatic resp(input logic w, input logic [15:0] e);
    cmd(acac_pkg::OP_ALERT_RESP, 2'h0, 16'h0, w);
    chk("alert reply", e, rv);
  endtask
  function automatic logic [15:0] cf(input int s, m, rt, w, p, l, q);
    return {s[0], 6'h00, m[0], rt[2:0], w[0], p[0], l[0], q[1:0]};
  endfunction
  task automatic tick;
    @(posedge ref_clk);
    #1;
    k++;
  endtask
  // set sample, start a conversion, wait power-up plus one data period
  task automatic go(input logic [15:0] s, input logic [15:0] cw);
    @(posedge ref_clk);
    #1;
    sample_data = s;
    wr(2'h1, cw);
    repeat (acac_pkg::POWERUP_CYCLES + (acac_pkg::CONV_TICKS[cw[7:5]] >> SH) * DIV + 40)
      @(posedge ref_clk);
    #1;
  endtask

  // hang guard
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 95000)
    begin
      bad_count++;
      complete_run();
    end
  end

  // main sequence
  initial
  begin
    ref_clk = 1'b0;
    link_clk = 1'b0;
    reset = 1'b1;
    addr_strap = 2'h1;
    sample_data = 16'h0;
    r = 0;
    repeat (8) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    pin(1'b0);
    rdc(2'h1, 16'h8583);
    rdc(2'h2, 16'h8000);
    rdc(2'h3, 16'h7fff);
    wr(2'h0, 16'h1234);
    rdc(2'h0, 16'h0000);
    wr(2'h2, 16'h0400);
    wr(2'h3, 16'h0800);
    // first shot, status low while busy
    c = cf(1, 1, 7, 0, 0, 0, 0);
    sample_data = 16'h1000;
    wr(2'h1, c);
    rdc(2'h1, c & 16'h7fff);
    repeat (acac_pkg::POWERUP_CYCLES + 80) @(posedge ref_clk);
    #1;
    rdc(2'h0, 16'h1000);
    rdc(2'h1, c);
    pin(1'b1);
    go(16'h0600, c);
    pin(1'b1);
    go(16'h0100, c);
    pin(1'b0);
    // queue depths, walking all rates
    for (int q = 0; q < 3; q++)
    begin
      for (int i = 0; i < (1 << q); i++)
      begin
        go(16'h1000, cf(1, 1, r, 0, 0, 0, q));
        r++;
        pin(i == (1 << q) - 1);
      end
      go(16'h0100, cf(1, 1, 7, 0, 0, 0, q));
    end
    // latched window alerts and alert replies
    c = cf(1, 1, 7, 1, 0, 1, 0);
    go(16'h1000, c);
    resp(1'b0, {8'h00, ADR, 1'b1});
    pin(1'b1);
    resp(1'b1, {8'h00, ADR, 1'b1});
    pin(1'b0);
    cmd(acac_pkg::OP_ALERT_RESP, 2'h0, 16'h0, 1'b1);
    chk("nack", 16'h1, {15'h0, host.rd_nack});
    go(16'h0100, c);
    pin(1'b1);
    go(16'h0600, c);
    pin(1'b1);
    resp(1'b1, {8'h00, ADR, 1'b0});
    pin(1'b0);
    go(16'h1000, c);
    rdc(2'h0, 16'h1000);
    pin(1'b0);
    go(16'h1000, c);
    rdc(2'h1, c);
    pin(1'b0);
    // polarity and comparator off
    go(16'h0600, cf(1, 1, 7, 0, 1, 0, 0));
    pin(1'b1);
    go(16'h1000, cf(1, 1, 7, 0, 1, 0, 0));
    pin(1'b0);
    go(16'h1000, cf(1, 1, 7, 0, 0, 0, 3));
    pin(1'b0);
    // conversion-ready pin, single then continuous
    wr(2'h2, 16'h0000);
    wr(2'h3, 16'h8000);
    go(16'h0100, cf(1, 1, 7, 1, 0, 1, 0));
    pin(1'b1);
    sample_data = 16'h2222;
    wr(2'h1, cf(0, 0, 0, 0, 0, 0, 0));
    k = 0;
    while (alert_oe && k < 5000) tick();
    while (!alert_oe && k < 9000) tick();
    k = 0;
    while (alert_oe && k < 2000) tick();
    chk("ready pulse", 16'(acac_pkg::READY_CYCLES), k[15:0]);
    rdc(2'h0, 16'h2222);
    @(posedge ref_clk);
    #1;
    sample_data = 16'h3333;
    repeat (1320) @(posedge ref_clk);
    rdc(2'h0, 16'h3333);
    // general-call reset
    cmd(acac_pkg::OP_GCALL_RESET, 2'h0, 16'h0, 1'b0);
    rdc(2'h1, 16'h8583);
    rdc(2'h3, 16'h7fff);
    pin(1'b0);
    complete_run();
  end
endmodule
